// ### rtl/esbt_pkg.sv
// Purpose: Shared constants and carriers for the bulk core store block transfer engine.
// Assumes: One clock domain at 100 MHz, asynchronous active-low reset.
// Notes: Register offsets are byte addresses of aligned 32-bit words on AHB-Lite.
//
// Functional notes
// - Read moves store to memory; write reverses.
// - Transfer parameters frozen; restart uses originals.
// - Negative word count raises range fault.
// - Fault stops if stop bit, else next word.
// - Memory field length must exceed end address.
// - Store end minus field length nonnegative faults.
// - Word 7 at store field length faults.
// - All range checks precede any transfer.
// - Error exit goes to lower instruction parcel.
// - Parity error exits only after whole block; code flags parity on reads only, a write ignores it.
// - Unavailable bank gives immediate error exit.
// - Nonexistent write address: no data, exit.
// - Nonexistent read address writes zeros to memory.
// - Exchange request waits for current record end.
// - Last record clean: next word, then exchange.
// - Last record errored: lower parcel, then exchange.
// - Unfinished block: save transfer address, redo all.
// - Start addresses are register plus base.
// - Low six base/length bits read zero; code clears them for store base/length only.
package esbt_pkg;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT_INDEX = 8'h08;
  localparam logic [7:0] REG_CONST_K = 8'h0c;
  localparam logic [7:0] REG_MEM_ADDR = 8'h10;
  localparam logic [7:0] REG_STORE_ADDR = 8'h14;
  localparam logic [7:0] REG_MEM_BASE = 8'h18;
  localparam logic [7:0] REG_MEM_FL = 8'h1c;
  localparam logic [7:0] REG_STORE_BASE = 8'h20;
  localparam logic [7:0] REG_STORE_FL = 8'h24;
  localparam logic [7:0] REG_PADDR = 8'h28;
  localparam logic [7:0] REG_NEXT_PADDR = 8'h2c;
  localparam logic [7:0] REG_WORDS_DONE = 8'h30;

  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_STOP_EN_BIT = 2;

  localparam int MEM_AW = 18;
  localparam int STORE_AW = 24;
  localparam int WORD_W = 60;
  localparam int CHECK_W = 60;
  localparam int STORE_LOW_ZERO = 6;
  localparam int RECORD_WORDS = 8;
  localparam logic [2:0] LAST_WORD_IN_RECORD = 3'h7;

  localparam logic [17:0] RESET_ADDR = 18'h00000;

  typedef enum logic [2:0] {
    ESBT_IDLE = 3'b000,
    ESBT_CHECK = 3'b001,
    ESBT_MOVE = 3'b011,
    ESBT_EXIT = 3'b010,
    ESBT_STOP = 3'b110
  } esbt_state_t;

  typedef enum logic [1:0] {
    ESBT_EXIT_NEXT = 2'h0,
    ESBT_EXIT_LOWER = 2'h1,
    ESBT_EXIT_REDO = 2'h2,
    ESBT_EXIT_STOP = 2'h3
  } esbt_exit_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [17:0] mem_addr;
    logic [23:0] store_addr;
    logic zero_fill;
  } esbt_xfer_t;

  typedef struct packed {
    logic ack;
    logic parity_err;
    logic bank_down;
    logic nonexist;
  } esbt_resp_t;

endpackage

// ### rtl/esbt_range_check.sv
// Purpose: Whole-block range checks for a bulk core store transfer.
// Assumes: Inputs held steady while the engine is in its check state.
// Notes: Pure combinational; the engine registers the verdict.
`timescale 1ns/1ps
`default_nettype none
module esbt_range_check (
  input wire logic [17:0] count_index_reg_i,
  input wire logic [17:0] const_k_i,
  input wire logic [17:0] memory_addr_reg_i,
  input wire logic [23:0] store_addr_reg_i,
  input wire logic [17:0] memory_field_length_i,
  input wire logic [23:0] store_field_length_i,
  output logic count_neg_o,
  output logic mem_fault_o,
  output logic store_fault_o,
  output logic word7_fault_o,
  output logic [17:0] count_o
);
  logic [18:0] count_sum;
  logic [19:0] mem_end;
  logic [59:0] store_diff;
  logic [59:0] store_last;
  always_comb begin
    count_sum = {count_index_reg_i[17], count_index_reg_i}
      + {const_k_i[17], const_k_i};
    count_neg_o = count_sum[18];
    count_o = count_sum[17:0];
    mem_end = {2'h0, memory_addr_reg_i} + {2'h0, count_sum[17:0]};
    mem_fault_o = ({2'h0, memory_field_length_i} <= mem_end);
    store_diff = {36'h0, store_addr_reg_i} + {42'h0, count_sum[17:0]}
      - {{36{store_field_length_i[23]}}, store_field_length_i};
    store_fault_o = !store_diff[59];
    store_last = {36'h0, store_addr_reg_i} + {42'h0, count_sum[17:0]}
      - 60'h1;
    word7_fault_o = (count_sum[17:0] != 18'h0)
      && (store_last[23:0] == {store_field_length_i[23:3], 3'h7});
  end
endmodule
`default_nettype wire

// ### rtl/esbt_engine.sv
// Purpose: Block transfer engine between central memory and the bulk core store.
// Assumes: Single-word AHB-Lite transfers; memory and store ports answer by ack.
// Notes: Words move one per ack; records are eight words for exchange breaks.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module esbt_engine (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic exchange_req_i,
  output logic exchange_go_o,
  output esbt_pkg::esbt_xfer_t xfer_o,
  input wire esbt_pkg::esbt_resp_t resp_i,
  output logic [59:0] mem_wdata_o,
  input wire logic [59:0] mem_rdata_i,
  output logic [59:0] store_wdata_o,
  input wire logic [59:0] store_rdata_i,
  output logic busy_o,
  output logic error_stop_o
);
  // ********************************************************
  // Register file
  // ********************************************************
  logic go, wr_dir, stop_en;
  logic [17:0] count_index_reg, const_k, memory_addr_reg, memory_base, memory_field_length;
  logic [23:0] store_addr_reg, store_base, store_field_length;
  logic [17:0] paddr, next_paddr_out;
  logic ap_valid, ap_write;
  logic [7:0] ap_addr;
  logic next_ap_valid, next_ap_write;
  logic [7:0] next_ap_addr;
  logic next_go, next_wr_dir, next_stop_en;
  logic [17:0] next_count_index_reg, next_const_k, next_memory_addr_reg;
  logic [17:0] next_memory_base, next_memory_field_length, next_paddr;
  logic [23:0] next_store_addr_reg, next_store_base, next_store_field_length;
  logic [31:0] next_hrdata;
  logic bus_lock;
  logic [1:0] exit_kind;
  logic [17:0] words_done;
  esbt_pkg::esbt_state_t state;

  // ********************************************************
  // Bus interface
  // ********************************************************
  // The slave never stalls, so a read is decoded in its address phase and
  // hrdata is already settled when the master samples it in the data phase.
  logic rd_ok;
  assign rd_ok = hsel && htrans[1] && !hwrite && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_lock = (state != esbt_pkg::ESBT_IDLE);

  always_comb begin
    // Only whole-word writes are taken; a narrower one is dropped, not half applied.
    next_ap_valid = hsel && htrans[1] && hwrite && hready && (hsize == 3'h2);
    next_ap_write = hwrite;
    next_ap_addr = haddr[7:0];
    // GO is a one-cycle pulse, so it always reads back as zero.
    next_go = 1'b0;
    next_wr_dir = wr_dir;
    next_stop_en = stop_en;
    next_count_index_reg = count_index_reg;
    next_const_k = const_k;
    next_memory_addr_reg = memory_addr_reg;
    next_store_addr_reg = store_addr_reg;
    next_memory_base = memory_base;
    next_memory_field_length = memory_field_length;
    next_store_base = store_base;
    next_store_field_length = store_field_length;
    next_paddr = paddr;
    next_hrdata = hrdata;
    // Parameters are frozen while a transfer runs so a restart sees originals.
    if (ap_valid && ap_write && !bus_lock) begin
      unique case (ap_addr)
        esbt_pkg::REG_CTRL: begin
          next_go = hwdata[esbt_pkg::CTRL_GO_BIT];
          next_wr_dir = hwdata[esbt_pkg::CTRL_WRITE_BIT];
          next_stop_en = hwdata[esbt_pkg::CTRL_STOP_EN_BIT];
        end
        esbt_pkg::REG_COUNT_INDEX: next_count_index_reg = hwdata[17:0];
        esbt_pkg::REG_CONST_K: next_const_k = hwdata[17:0];
        esbt_pkg::REG_MEM_ADDR: next_memory_addr_reg = hwdata[17:0];
        esbt_pkg::REG_STORE_ADDR: next_store_addr_reg = hwdata[23:0];
        esbt_pkg::REG_MEM_BASE: next_memory_base = hwdata[17:0];
        esbt_pkg::REG_MEM_FL: next_memory_field_length = hwdata[17:0];
        esbt_pkg::REG_STORE_BASE: next_store_base = {hwdata[23:6], 6'h00};
        esbt_pkg::REG_STORE_FL: next_store_field_length = {hwdata[23:6], 6'h00};
        esbt_pkg::REG_PADDR: next_paddr = hwdata[17:0];
        default: ;
      endcase
    end
    if (rd_ok) begin
      unique case (haddr[7:0])
        esbt_pkg::REG_CTRL: next_hrdata = {29'h0, stop_en, wr_dir, 1'b0};
        esbt_pkg::REG_STATUS: next_hrdata = {27'h0, exit_kind, state};
        esbt_pkg::REG_COUNT_INDEX: next_hrdata = {14'h0, count_index_reg};
        esbt_pkg::REG_CONST_K: next_hrdata = {14'h0, const_k};
        esbt_pkg::REG_MEM_ADDR: next_hrdata = {14'h0, memory_addr_reg};
        esbt_pkg::REG_STORE_ADDR: next_hrdata = {8'h0, store_addr_reg};
        esbt_pkg::REG_MEM_BASE: next_hrdata = {14'h0, memory_base};
        esbt_pkg::REG_MEM_FL: next_hrdata = {14'h0, memory_field_length};
        esbt_pkg::REG_STORE_BASE: next_hrdata = {8'h0, store_base};
        esbt_pkg::REG_STORE_FL: next_hrdata = {8'h0, store_field_length};
        esbt_pkg::REG_PADDR: next_hrdata = {14'h0, paddr};
        esbt_pkg::REG_NEXT_PADDR: next_hrdata = {14'h0, next_paddr_out};
        esbt_pkg::REG_WORDS_DONE: next_hrdata = {14'h0, words_done};
        default: next_hrdata = 32'h0;
      endcase
    end
  end

  // ********************************************************
  // Register file flip-flops
  // ********************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h0;
      go <= 1'b0;
      wr_dir <= 1'b0;
      stop_en <= 1'b0;
      count_index_reg <= 18'h0;
      const_k <= 18'h0;
      memory_addr_reg <= 18'h0;
      store_addr_reg <= 24'h0;
      memory_base <= 18'h0;
      memory_field_length <= 18'h0;
      store_base <= 24'h0;
      store_field_length <= 24'h0;
      paddr <= esbt_pkg::RESET_ADDR;
      hrdata <= 32'h0;
    end else begin
      ap_valid <= next_ap_valid;
      ap_write <= next_ap_write;
      ap_addr <= next_ap_addr;
      go <= next_go;
      wr_dir <= next_wr_dir;
      stop_en <= next_stop_en;
      count_index_reg <= next_count_index_reg;
      const_k <= next_const_k;
      memory_addr_reg <= next_memory_addr_reg;
      store_addr_reg <= next_store_addr_reg;
      memory_base <= next_memory_base;
      memory_field_length <= next_memory_field_length;
      store_base <= next_store_base;
      store_field_length <= next_store_field_length;
      paddr <= next_paddr;
      hrdata <= next_hrdata;
    end
  end

  // ********************************************************
  // Range checks
  // ********************************************************
  logic count_neg, mem_fault, store_fault, word7_fault;
  logic [17:0] count;
  // The checker is combinational; its verdict matters only in the CHECK state.
  esbt_range_check u_check (
    .count_index_reg_i(count_index_reg),
    .const_k_i(const_k),
    .memory_addr_reg_i(memory_addr_reg),
    .store_addr_reg_i(store_addr_reg),
    .memory_field_length_i(memory_field_length),
    .store_field_length_i(store_field_length),
    .count_neg_o(count_neg),
    .mem_fault_o(mem_fault),
    .store_fault_o(store_fault),
    .word7_fault_o(word7_fault),
    .count_o(count)
  );

  // ********************************************************
  // Transfer sequencer
  // ********************************************************
  esbt_pkg::esbt_state_t next_state;
  logic [17:0] mem_ptr, next_mem_ptr, next_words_done;
  logic [23:0] store_ptr, next_store_ptr;
  logic parity_seen, next_parity_seen, xchg_pend, next_xchg_pend;
  logic [1:0] next_exit_kind;
  logic [17:0] next_paddr_reg;
  logic next_exchange_go, next_error_stop, next_req;
  logic word_req;
  logic [59:0] next_mem_wdata, next_store_wdata;
  logic any_fault, record_end, last_word;

  // Any single check failing stops the block before its first word.
  assign any_fault = count_neg || mem_fault || store_fault || word7_fault;
  // Compared against the word being answered, so the last answer leaves MOVE.
  assign last_word = (words_done + 18'h1 == count);
  // Records are eight words long; an exchange may break in only at their ends.
  assign record_end = (words_done[2:0] == esbt_pkg::LAST_WORD_IN_RECORD);

  always_comb begin
    next_state = state;
    next_mem_ptr = mem_ptr;
    next_store_ptr = store_ptr;
    next_words_done = words_done;
    next_parity_seen = parity_seen;
    next_xchg_pend = xchg_pend || exchange_req_i;
    next_exit_kind = exit_kind;
    next_paddr_reg = next_paddr_out;
    next_exchange_go = 1'b0;
    next_error_stop = error_stop_o;
    next_req = 1'b0;
    next_mem_wdata = mem_wdata_o;
    next_store_wdata = store_wdata_o;
    unique case (state)
      esbt_pkg::ESBT_IDLE: begin
        // An exchange that arrives while idle needs no holding here.
        next_xchg_pend = 1'b0;
        if (go) begin
          next_state = esbt_pkg::ESBT_CHECK;
          next_parity_seen = 1'b0;
          next_words_done = 18'h0;
        end
      end
      esbt_pkg::ESBT_CHECK: begin
        // Start addresses are formed once; the pointers then step together.
        next_mem_ptr = memory_addr_reg + memory_base;
        next_store_ptr = store_addr_reg + store_base;
        // A fault moves no word, whatever the stop bit says.
        if (any_fault) begin
          next_state = esbt_pkg::ESBT_IDLE;
          if (stop_en) begin
            next_exit_kind = esbt_pkg::ESBT_EXIT_STOP;
            next_error_stop = 1'b1;
          end else begin
            next_exit_kind = esbt_pkg::ESBT_EXIT_NEXT;
            next_paddr_reg = paddr + 18'h1;
          end
        end else if (count == 18'h0) begin
          next_state = esbt_pkg::ESBT_EXIT;
        end else begin
          next_state = esbt_pkg::ESBT_MOVE;
          next_req = 1'b1;
        end
      end
      esbt_pkg::ESBT_MOVE: begin
        next_req = 1'b1;
        if (resp_i.ack) begin
          // Bank loss and a missing write address end the block at once.
          if (resp_i.bank_down || (resp_i.nonexist && wr_dir)) begin
            next_req = 1'b0;
            next_parity_seen = 1'b1;
            next_state = esbt_pkg::ESBT_EXIT;
          end else begin
            if (!wr_dir) begin
              next_mem_wdata = resp_i.nonexist ? 60'h0 : store_rdata_i;
              // The error flag covers parity and missing read addresses alike;
              // both let the block run to its end before the lower-parcel exit.
              next_parity_seen = parity_seen || resp_i.parity_err
                || resp_i.nonexist;
            end else begin
              next_store_wdata = mem_rdata_i;
            end
            next_words_done = words_done + 18'h1;
            next_mem_ptr = mem_ptr + 18'h1;
            next_store_ptr = store_ptr + 24'h1;
            if (last_word) begin
              next_req = 1'b0;
              next_state = esbt_pkg::ESBT_EXIT;
            // An unfinished block is redone from scratch, so P still names it.
            end else if (record_end && next_xchg_pend) begin
              next_req = 1'b0;
              next_state = esbt_pkg::ESBT_IDLE;
              next_exit_kind = esbt_pkg::ESBT_EXIT_REDO;
              next_paddr_reg = paddr;
              next_exchange_go = 1'b1;
            end
          end
        end
      end
      esbt_pkg::ESBT_EXIT: begin
        next_state = esbt_pkg::ESBT_IDLE;
        // A pending exchange follows the exit, so the saved P is already final.
        next_exchange_go = next_xchg_pend;
        if (parity_seen) begin
          next_exit_kind = esbt_pkg::ESBT_EXIT_LOWER;
          next_paddr_reg = paddr;
        end else begin
          next_exit_kind = esbt_pkg::ESBT_EXIT_NEXT;
          next_paddr_reg = paddr + 18'h1;
        end
      end
      default: next_state = esbt_pkg::ESBT_IDLE;
    endcase
  end

  // ********************************************************
  // Sequencer flip-flops
  // ********************************************************
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= esbt_pkg::ESBT_IDLE;
      mem_ptr <= 18'h0;
      store_ptr <= 24'h0;
      words_done <= 18'h0;
      parity_seen <= 1'b0;
      xchg_pend <= 1'b0;
      exit_kind <= esbt_pkg::ESBT_EXIT_NEXT;
      next_paddr_out <= 18'h0;
      exchange_go_o <= 1'b0;
      error_stop_o <= 1'b0;
      word_req <= 1'b0;
      mem_wdata_o <= 60'h0;
      store_wdata_o <= 60'h0;
    end else begin
      state <= next_state;
      mem_ptr <= next_mem_ptr;
      store_ptr <= next_store_ptr;
      words_done <= next_words_done;
      parity_seen <= next_parity_seen;
      xchg_pend <= next_xchg_pend;
      exit_kind <= next_exit_kind;
      next_paddr_out <= next_paddr_reg;
      exchange_go_o <= next_exchange_go;
      error_stop_o <= next_error_stop;
      word_req <= next_req;
      mem_wdata_o <= next_mem_wdata;
      store_wdata_o <= next_store_wdata;
    end
  end

  // ********************************************************
  // Far-side port
  // ********************************************************
  // Every field but zero_fill, which is tied low, comes straight from a flip-flop, so the far side sees no glitches.
  assign xfer_o.req = word_req;
  assign xfer_o.wr = wr_dir;
  assign xfer_o.mem_addr = mem_ptr;
  assign xfer_o.store_addr = store_ptr;
  assign xfer_o.zero_fill = 1'b0;
  assign busy_o = (state != esbt_pkg::ESBT_IDLE);
endmodule
`default_nettype wire

// ### bench/esbt_assertions.sv
// Purpose: Concurrent checks on the transfer engine's far-side ports.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound onto the engine at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module esbt_checker (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic exchange_go_o,
  input wire esbt_pkg::esbt_xfer_t xfer_o,
  input wire esbt_pkg::esbt_resp_t resp_i,
  input wire logic [59:0] mem_wdata_o,
  input wire logic [59:0] store_wdata_o,
  input wire logic [59:0] mem_rdata_i,
  input wire logic [59:0] store_rdata_i,
  input wire logic error_stop_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic took;
  assign took = xfer_o.req && resp_i.ack;
  // ****************
  // Word handshake
  // ****************
  a_req_hold: assert property (xfer_o.req && !resp_i.ack |=> xfer_o.req && $stable(xfer_o))
    else $error("request moved before answer");
  a_addr_step: assert property (took ##1 xfer_o.req |->
    xfer_o.mem_addr == $past(xfer_o.mem_addr) + 18'h1 &&
    xfer_o.store_addr == $past(xfer_o.store_addr) + 24'h1) else $error("address step wrong");
  a_read_data: assert property (took && !xfer_o.wr && !resp_i.nonexist && !resp_i.bank_down
    |=> mem_wdata_o == $past(store_rdata_i)) else $error("read word lost");
  a_write_data: assert property (took && xfer_o.wr && !resp_i.nonexist && !resp_i.bank_down
    |=> store_wdata_o == $past(mem_rdata_i)) else $error("write word lost");
  a_zero_read: assert property (took && !xfer_o.wr && resp_i.nonexist
    |=> mem_wdata_o == 60'h0) else $error("missing word not zeroed");
  a_bank_exit: assert property (took && resp_i.bank_down |=> !xfer_o.req)
    else $error("no exit on bank down");
  a_nowrite_exit: assert property (took && xfer_o.wr && resp_i.nonexist |=> !xfer_o.req)
    else $error("no exit on missing write");
  a_exch_after: assert property (exchange_go_o |-> !xfer_o.req ##1 !exchange_go_o)
    else $error("exchange during word");
  a_stop_hold: assert property (error_stop_o |=> error_stop_o && !xfer_o.req)
    else $error("stop not held");
endmodule
bind esbt_engine esbt_checker chk_u (.clock_i, .rst_n_i, .exchange_go_o, .xfer_o, .resp_i,
  .mem_wdata_o, .store_wdata_o, .mem_rdata_i, .store_rdata_i, .error_stop_o);
`default_nettype wire

// ### bench/esbt_store_model.sv
// Purpose: Far-side model of central memory and the bulk store banks.
// Assumes: The engine holds each word request until it is answered.
// Notes: fault_i picks the answer kind; slow_i adds two wait cycles.
`timescale 1ns/1ps
`default_nettype none
module esbt_store_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire esbt_pkg::esbt_xfer_t xfer_i,
  input wire logic [1:0] fault_i,
  input wire logic slow_i,
  input wire logic [59:0] mem_wdata_i,
  input wire logic [59:0] store_wdata_i,
  output var esbt_pkg::esbt_resp_t resp_o,
  output logic [59:0] mem_rdata_o,
  output logic [59:0] store_rdata_o
);
  logic [1:0] wait_q;
  logic took_q;
  logic wr_q;
  logic [5:0] ma_q;
  logic [5:0] sa_q;
  logic ack;
  int n_ack;
  logic [59:0] mem_img [64];
  logic [59:0] store_img [64];
  // ****************
  // Answers
  // ****************
  assign ack = xfer_i.req && (wait_q == (slow_i ? 2'h2 : 2'h0));
  assign resp_o = {ack, ack && fault_i == 2'h1, ack && fault_i == 2'h2, ack && fault_i == 2'h3};
  // Outside the answering cycle the lines show the inverse, so stale data cannot pass.
  assign store_rdata_o = {60{!ack}} ^ {36'h5a5a5a5a5, xfer_i.store_addr};
  assign mem_rdata_o = {60{!ack}} ^ {42'h3c3c3c3c3c, xfer_i.mem_addr};
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 2'h0;
      took_q <= 1'b0;
      n_ack <= 0;
    end else begin
      wait_q <= (ack || !xfer_i.req) ? 2'h0 : wait_q + 2'h1;
      // A refused word lands nowhere: no bank, or no such address on a write.
      took_q <= ack && !resp_o.bank_down && !(resp_o.nonexist && xfer_i.wr);
      wr_q <= xfer_i.wr;
      ma_q <= xfer_i.mem_addr[5:0];
      sa_q <= xfer_i.store_addr[5:0];
      n_ack <= n_ack + (ack ? 1 : 0);
      if (took_q && wr_q) store_img[sa_q] <= store_wdata_i;
      if (took_q && !wr_q) mem_img[ma_q] <= mem_wdata_i;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
// Purpose: Self-checking bench for the bulk store transfer engine.
// Assumes: Zero-wait register bus; the far-side model answers every word.
// Notes: Small word counts keep each run short.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, exch_go, busy, stop;
  logic exch = 1'b0;
  logic slow = 1'b0;
  logic [1:0] fault = 2'h0;
  logic [59:0] mwd, mrd, swd, srd;
  esbt_pkg::esbt_xfer_t xfer;
  esbt_pkg::esbt_resp_t resp;
  int mismatches = 0;
  int checks_done = 0;
  int n_go = 0;
  always #5 clock_i = ~clock_i;
  esbt_engine dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .exchange_req_i(exch),
    .exchange_go_o(exch_go), .xfer_o(xfer), .resp_i(resp), .mem_wdata_o(mwd),
    .mem_rdata_i(mrd), .store_wdata_o(swd), .store_rdata_i(srd), .busy_o(busy),
    .error_stop_o(stop));
  esbt_store_model part_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .xfer_i(xfer),
    .fault_i(fault), .slow_i(slow), .mem_wdata_i(mwd), .store_wdata_i(swd), .resp_o(resp),
    .mem_rdata_o(mrd), .store_rdata_o(srd));
  always @(posedge clock_i) if (exch_go === 1'b1) begin
    n_go <= n_go + 1;
    exch <= 1'b0;
  end
  // ****************
  // Tasks
  // ****************
  task results;
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(posedge clock_i); n++; end while (hreadyout !== 1'b1 && n < 20);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge clock_i); n++; end while (hreadyout !== 1'b1 && n < 40);
    q = hrdata;
    if (n >= 40) begin mismatches++; results(); end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task setp(input logic [17:0] bj, input logic [17:0] kk, input logic [31:0] mfl);
    wr(esbt_pkg::REG_COUNT_INDEX, {14'h0, bj});
    wr(esbt_pkg::REG_CONST_K, {14'h0, kk});
    wr(esbt_pkg::REG_MEM_FL, mfl);
  endtask
  task go(input logic wd, input logic sp, input logic xr, output logic [31:0] st,
          output logic [31:0] np, output logic [31:0] nw);
    int n;
    n = 0;
    wr(esbt_pkg::REG_CTRL, {29'h0, sp, wd, 1'b1});
    if (xr) begin
      exch <= 1'b1;
      wr(esbt_pkg::REG_COUNT_INDEX, 32'h0);
    end
    repeat (2) @(posedge clock_i);
    while (busy !== 1'b0 && stop !== 1'b1 && n < 2000) begin @(posedge clock_i); n++; end
    if (n >= 2000) begin mismatches++; results(); end
    bus(1'b0, esbt_pkg::REG_STATUS, 32'h0, st);
    bus(1'b0, esbt_pkg::REG_NEXT_PADDR, 32'h0, np);
    bus(1'b0, esbt_pkg::REG_WORDS_DONE, 32'h0, nw);
  endtask
  // ****************
  // Scenarios
  // ****************
  initial begin
    logic [31:0] st, np, nw, q;
    int a0, g0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    wr(esbt_pkg::REG_STORE_BASE, 32'h7f);
    bus(1'b0, esbt_pkg::REG_STORE_BASE, 32'h0, q);
    chk("store base", q, 32'h40);
    wr(esbt_pkg::REG_STORE_FL, 32'h7f);
    bus(1'b0, esbt_pkg::REG_STORE_FL, 32'h0, q);
    chk("store length", q, 32'h40);
    wr(esbt_pkg::REG_MEM_ADDR, 32'h4);
    wr(esbt_pkg::REG_STORE_ADDR, 32'h3);
    wr(esbt_pkg::REG_MEM_BASE, 32'h10);
    wr(esbt_pkg::REG_PADDR, 32'h100);
    for (int d = 0; d < 2; d++) begin
      slow <= (d == 0);
      setp(18'h5, 18'h7, 32'h20);
      go(d[0], 1'b0, 1'b0, st, np, nw);
      chk("clean exit", st[4:3], 0);
      chk("clean next", np, 32'h101);
      chk("clean words", nw, 12);
      for (int i = 0; i < 12; i++) begin
        if (d == 0) chk("mem word", part_u.mem_img[6'(8'h14 + i)],
          {36'h5a5a5a5a5, 24'(8'h43 + i)});
        else chk("store word", part_u.store_img[6'(3 + i)],
          {42'h3c3c3c3c3c, 18'(8'h14 + i)});
      end
    end
    for (int f = 0; f < 3; f++) begin
      a0 = part_u.n_ack;
      if (f == 0) setp(18'h3fffd, 18'h1, 32'h20);
      if (f == 1) setp(18'h5, 18'h7, 32'h10);
      if (f == 2) setp(18'h5, 18'h38, 32'h42);
      go(1'b0, 1'b0, 1'b0, st, np, nw);
      chk("fault exit", st[4:3], 0);
      chk("fault next", np, 32'h101);
      chk("fault words", part_u.n_ack - a0, 0);
    end
    for (int e = 0; e < 5; e++) begin
      fault <= (e == 0) ? 2'h1 : (e < 3) ? 2'h2 : 2'h3;
      setp(18'h5, 18'h7, 32'h20);
      go(e == 2 || e == 3, 1'b0, 1'b0, st, np, nw);
      chk("error exit", st[4:3], 1);
      chk("error next", np, 32'h100);
      chk("error words", nw, (e == 0 || e == 4) ? 12 : 0);
      if (e == 2 || e == 3) chk("store untouched", part_u.store_img[6'h3],
        {42'h3c3c3c3c3c, 18'h14});
    end
    for (int i = 0; i < 12; i++) chk("cleared", part_u.mem_img[6'(8'h14 + i)], 0);
    slow <= 1'b1;
    for (int x = 0; x < 3; x++) begin
      fault <= (x == 2) ? 2'h1 : 2'h0;
      a0 = part_u.n_ack;
      g0 = n_go;
      setp(x == 0 ? 18'h5 : 18'h1, 18'h7, 32'h20);
      go(1'b0, 1'b0, 1'b1, st, np, nw);
      chk("exchange exit", st[4:3], x == 0 ? 2 : x - 1);
      chk("exchange next", np, x == 1 ? 32'h101 : 32'h100);
      chk("exchange pulse", n_go - g0, 1);
      chk("record words", part_u.n_ack - a0, 8);
      bus(1'b0, esbt_pkg::REG_COUNT_INDEX, 32'h0, q);
      chk("frozen index", q, x == 0 ? 32'h5 : 32'h1);
    end
    fault <= 2'h0;
    a0 = part_u.n_ack;
    setp(18'h3fffd, 18'h1, 32'h20);
    go(1'b0, 1'b1, 1'b0, st, np, nw);
    chk("stop exit", st[4:3], 3);
    chk("stop flag", stop, 1);
    chk("stop words", part_u.n_ack - a0, 0);
    results();
  end
endmodule
`default_nettype wire
